//--- shared/sdram_pkg.sv
/*
 * shared constants, types and encodings for the sdram init / mode / burst block.
 * assumes: every user writes sdram_pkg::name, nothing imports this package.
 */
package sdram_pkg;

  // ****************************************
  // link geometry
  // ****************************************
  localparam int ADDR_W = 13;
  localparam int COL_W = 10;
  localparam int BEAT_W = 4;

  // ****************************************
  // command codes on {ras_n, cas_n, we_n}
  // ****************************************
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_AREF = 3'h1;
  localparam logic [2:0] CMD_LMR = 3'h0;
  localparam logic [2:0] CMD_BST = 3'h6;
  localparam int PRE_ALL_BIT = 10;
  localparam logic [1:0] BA_MODE = 2'h0;
  localparam logic [1:0] BA_EXT = 2'h2;
  localparam logic [1:0] AREF_NEEDED = 2'h2;

  // ****************************************
  // standard mode register layout
  // ****************************************
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam int MR_OPM_LSB = 7;
  localparam logic [2:0] BL_CODE_2 = 3'h1;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] BL_CODE_16 = 3'h4;
  localparam logic [2:0] CL_CODE_2 = 3'h2;
  localparam logic [1:0] CL_2 = 2'h2;
  localparam logic [1:0] CL_3 = 2'h3;
  localparam logic [1:0] WL = 2'h1;
  localparam logic [ADDR_W-1:0] MODE_RST = 13'h0031;
  localparam logic [ADDR_W-1:0] EXT_RST = 13'h0000;

  // ****************************************
  // apb register map
  // ****************************************
  localparam int PADDR_W = 12;
  localparam logic [PADDR_W-1:0] OFS_CTRL = 12'h000;
  localparam logic [PADDR_W-1:0] OFS_STATUS = 12'h004;
  localparam logic [PADDR_W-1:0] OFS_MODE = 12'h008;
  localparam logic [PADDR_W-1:0] OFS_EXT = 12'h00C;
  localparam logic [PADDR_W-1:0] OFS_BURST = 12'h010;
  localparam int CTRL_CLR_BIT = 0;
  localparam int CTRL_STRICT_BIT = 1;
  localparam logic CTRL_STRICT_RST = 1'b1;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {INIT_PRE, INIT_SEQ, INIT_READY} init_e;

  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [ADDR_W-1:0] addr;
  } pins_s;

  typedef struct packed {
    logic valid;
    logic is_read;
    logic [COL_W-1:0] col;
  } beat_s;

endpackage

//--- src/sync2.sv
/*
 * two flip-flop synchroniser for a bundle of slow pins.
 * assumes: bits are independent levels; the bundle may skew by one cycle.
 */
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pins in, synchronised out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

//--- src/burst_order.sv
/*
 * column address of one beat inside a wrapped burst block.
 * assumes: bl_log is 1..4 and idx is below the burst length.
 */
`timescale 1ns/1ps
module burst_order #(
  parameter int COL_W = 10
) (
  // burst description
  input wire logic [COL_W-1:0] start_col,
  input wire logic [2:0] bl_log,
  input wire logic interleave,
  input wire logic [3:0] idx,
  // column of this beat
  output logic [COL_W-1:0] col
);

  logic [4:0] span;
  logic [3:0] mask;
  logic [3:0] low;
  logic [3:0] ofs;

  // block bits stay, low bits wrap inside the block
  always_comb begin
    span = 5'h01 << bl_log;
    mask = 4'(span - 5'h01);
    low = start_col[3:0];
    ofs = interleave ? (low ^ idx) : 4'(low + idx);
    col = {start_col[COL_W-1:4], (low & ~mask) | (ofs & mask)};
  end

endmodule

//--- src/sdram_init_mode_burst.sv
/*
 * sdram die front end: follows the init sequence on the command pins, holds
 * the standard and extended mode registers, and walks the columns of each
 * read or write burst; software sees it all over apb.
 * assumes: link pins and mem_ck come from another clock domain, mem_ck is
 * much slower than pclk, the memory array itself lives elsewhere.
 */
`timescale 1ns/1ps
module sdram_init_mode_burst #(
  parameter int COL_W = sdram_pkg::COL_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [sdram_pkg::PADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // command link from the controller
  input wire logic mem_ck,
  input wire sdram_pkg::pins_s mem_pins,
  // beat stream toward the array
  output logic [COL_W-1:0] beat_col,
  output logic beat_valid,
  output logic beat_read,
  output logic init_ready
);

  // ****************************************
  // link sampling
  // ****************************************
  sdram_pkg::pins_s pins_s2;
  logic ck_s2;
  sdram_pkg::pins_s pins_d_r;
  logic ck_d_r;
  logic cke_prev_r;
  logic rise;
  logic fall;
  logic [2:0] cmd;
  logic cmd_ok;
  logic dpd_entry;

  sync2 #(
    .WIDTH($bits(sdram_pkg::pins_s) + 1)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({mem_ck, mem_pins}),
    .q({ck_s2, pins_s2})
  );

  // pins_d_r is the value seen just before the clock edge was found
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_d_r <= 1'b0;
      pins_d_r <= '0;
      cke_prev_r <= 1'b0;
    end else begin
      ck_d_r <= ck_s2;
      pins_d_r <= pins_s2;
      cke_prev_r <= rise ? pins_d_r.cke : cke_prev_r;
    end
  end

  // commands other than deep power-down entry count only with clock enable high on both edges
  assign rise = ck_s2 & ~ck_d_r;
  assign fall = ~ck_s2 & ck_d_r;
  assign cmd = {pins_d_r.ras_n, pins_d_r.cas_n, pins_d_r.we_n};
  assign cmd_ok = rise & cke_prev_r & pins_d_r.cke & ~pins_d_r.cs_n & (cmd != sdram_pkg::CMD_NOP);

  // ****************************************
  // init tracking and mode registers
  // ****************************************
  sdram_pkg::init_e init_r, init_nxt;
  logic [1:0] aref_cnt_r, aref_cnt_nxt;
  logic mr_done_r, mr_done_nxt;
  logic emr_done_r, emr_done_nxt;
  logic [sdram_pkg::ADDR_W-1:0] mode_r, mode_nxt;
  logic [sdram_pkg::ADDR_W-1:0] ext_r, ext_nxt;
  logic err_r, err_nxt;
  logic rsvd_r, rsvd_nxt;
  logic strict_r, strict_nxt;
  logic err_clr;
  logic bad_cmd;
  logic burst_active_r, burst_active_nxt;

  // deep power-down entry: clock enable falls with burst terminate while idle
  assign dpd_entry = rise & cke_prev_r & ~pins_d_r.cke & ~pins_d_r.cs_n
    & (cmd == sdram_pkg::CMD_BST) & ~burst_active_r;

  always_comb begin
    init_nxt = init_r;
    aref_cnt_nxt = aref_cnt_r;
    mr_done_nxt = mr_done_r;
    emr_done_nxt = emr_done_r;
    mode_nxt = mode_r;
    ext_nxt = ext_r;
    rsvd_nxt = rsvd_r;
    bad_cmd = 1'b0;
    if (dpd_entry) begin
      // registers lost, full init needed again
      init_nxt = sdram_pkg::INIT_PRE;
      aref_cnt_nxt = '0;
      mr_done_nxt = 1'b0;
      emr_done_nxt = 1'b0;
      mode_nxt = sdram_pkg::MODE_RST;
      ext_nxt = sdram_pkg::EXT_RST;
    end else if (cmd_ok) begin
      if (init_r == sdram_pkg::INIT_PRE) begin
        if (cmd == sdram_pkg::CMD_PRE && pins_d_r.addr[sdram_pkg::PRE_ALL_BIT]) begin
          init_nxt = sdram_pkg::INIT_SEQ;
        end else begin
          bad_cmd = 1'b1;
        end
      end else begin
        if (cmd == sdram_pkg::CMD_LMR) begin
          // loads touch only the registers, never the array
          if (pins_d_r.ba == sdram_pkg::BA_MODE) begin
            mode_nxt = pins_d_r.addr;
            mr_done_nxt = 1'b1;
            rsvd_nxt = rsvd_r | (pins_d_r.addr[sdram_pkg::ADDR_W-1:sdram_pkg::MR_OPM_LSB] != '0);
          end else if (pins_d_r.ba == sdram_pkg::BA_EXT) begin
            ext_nxt = pins_d_r.addr;
            emr_done_nxt = 1'b1;
          end
          if (burst_active_r) begin
            bad_cmd = 1'b1;
          end
        end else if (cmd == sdram_pkg::CMD_AREF) begin
          if (aref_cnt_r != sdram_pkg::AREF_NEEDED) begin
            aref_cnt_nxt = 2'(aref_cnt_r + 2'h1);
          end
        end else if (init_r == sdram_pkg::INIT_SEQ && cmd != sdram_pkg::CMD_PRE) begin
          bad_cmd = 1'b1;
        end
      end
      // both loads in either order plus two refreshes
      if (init_r == sdram_pkg::INIT_SEQ && aref_cnt_nxt == sdram_pkg::AREF_NEEDED
          && mr_done_nxt && emr_done_nxt) begin
        init_nxt = sdram_pkg::INIT_READY;
      end
    end
    // a new error wins over a clear in the same cycle
    err_nxt = (err_r & ~err_clr) | (bad_cmd & strict_r);
  end

  // power loss is presetn: everything returns to the start of init
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_r <= sdram_pkg::INIT_PRE;
      aref_cnt_r <= '0;
      mr_done_r <= 1'b0;
      emr_done_r <= 1'b0;
      mode_r <= sdram_pkg::MODE_RST;
      ext_r <= sdram_pkg::EXT_RST;
      err_r <= 1'b0;
      rsvd_r <= 1'b0;
    end else begin
      init_r <= init_nxt;
      aref_cnt_r <= aref_cnt_nxt;
      mr_done_r <= mr_done_nxt;
      emr_done_r <= emr_done_nxt;
      mode_r <= mode_nxt;
      ext_r <= ext_nxt;
      err_r <= err_nxt;
      rsvd_r <= rsvd_nxt;
    end
  end

  // ****************************************
  // burst sequencing
  // ****************************************
  logic [2:0] bl_log;
  logic [1:0] cl;
  logic [COL_W-1:0] start_r, start_nxt;
  logic read_r, read_nxt;
  logic [1:0] wait_r, wait_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic [3:0] last_idx;
  logic go;
  logic [COL_W-1:0] col_now;
  sdram_pkg::beat_s beat_r, beat_nxt;

  // decode length and latency fields; reserved length codes fall back to the shortest, latency codes other than 2 give 3
  always_comb begin
    unique case (mode_r[sdram_pkg::MR_BL_LSB +: 3])
      sdram_pkg::BL_CODE_4: bl_log = 3'h2;
      sdram_pkg::BL_CODE_8: bl_log = 3'h3;
      sdram_pkg::BL_CODE_16: bl_log = 3'h4;
      default: bl_log = 3'h1;
    endcase
    cl = (mode_r[sdram_pkg::MR_CL_LSB +: 3] == sdram_pkg::CL_CODE_2) ?
      sdram_pkg::CL_2 : sdram_pkg::CL_3;
    last_idx = 4'((5'h01 << bl_log) - 5'h01);
  end

  burst_order #(
    .COL_W(COL_W)
  ) u_order (
    .start_col(start_r),
    .bl_log(bl_log),
    .interleave(mode_r[sdram_pkg::MR_BT_BIT]),
    .idx(idx_r),
    .col(col_now)
  );

  // one beat per link edge once the latency has run out
  always_comb begin
    start_nxt = start_r;
    read_nxt = read_r;
    wait_nxt = wait_r;
    idx_nxt = idx_r;
    burst_active_nxt = burst_active_r;
    beat_nxt = '0;
    go = burst_active_r & ((fall & wait_r == 2'h0) | (rise & wait_r <= 2'h1));
    if (go) begin
      beat_nxt.valid = 1'b1;
      beat_nxt.is_read = read_r;
      beat_nxt.col = col_now;
      idx_nxt = 4'(idx_r + 4'h1);
      burst_active_nxt = (idx_r != last_idx);
    end
    if (rise && wait_r != 2'h0) begin
      wait_nxt = 2'(wait_r - 2'h1);
    end
    if (dpd_entry) begin
      burst_active_nxt = 1'b0;
    end else if (cmd_ok && init_r == sdram_pkg::INIT_READY) begin
      if (cmd == sdram_pkg::CMD_READ || cmd == sdram_pkg::CMD_WRITE) begin
        // a new access cuts the old burst short
        start_nxt = pins_d_r.addr[COL_W-1:0];
        read_nxt = (cmd == sdram_pkg::CMD_READ);
        wait_nxt = (cmd == sdram_pkg::CMD_READ) ? 2'(cl - 2'h1) : sdram_pkg::WL;
        idx_nxt = '0;
        burst_active_nxt = 1'b1;
      end else if (cmd == sdram_pkg::CMD_BST && read_r) begin
        burst_active_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_r <= '0;
      read_r <= 1'b0;
      wait_r <= '0;
      idx_r <= '0;
      burst_active_r <= 1'b0;
      beat_r <= '0;
    end else begin
      start_r <= start_nxt;
      read_r <= read_nxt;
      wait_r <= wait_nxt;
      idx_r <= idx_nxt;
      burst_active_r <= burst_active_nxt;
      beat_r <= beat_nxt;
    end
  end

  assign beat_col = beat_r.col;
  assign beat_valid = beat_r.valid;
  assign beat_read = beat_r.is_read;

  // ****************************************
  // apb register file
  // ****************************************
  logic ready_r, ready_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic wr_take;
  logic hit;

  // pready rises in the access phase, so every transfer takes two cycles
  assign wr_take = psel & penable & pready_r & pwrite;
  assign err_clr = wr_take & (paddr == sdram_pkg::OFS_CTRL) & pwdata[sdram_pkg::CTRL_CLR_BIT];

  always_comb begin
    strict_nxt = strict_r;
    if (wr_take && paddr == sdram_pkg::OFS_CTRL) begin
      strict_nxt = pwdata[sdram_pkg::CTRL_STRICT_BIT];
    end
    hit = 1'b1;
    prdata_nxt = '0;
    unique case (paddr)
      sdram_pkg::OFS_CTRL: prdata_nxt[sdram_pkg::CTRL_STRICT_BIT] = strict_r;
      sdram_pkg::OFS_STATUS: prdata_nxt[7:0] = {emr_done_r, mr_done_r, aref_cnt_r,
        burst_active_r, rsvd_r, err_r, ready_r};
      sdram_pkg::OFS_MODE: prdata_nxt[sdram_pkg::ADDR_W-1:0] = mode_r;
      sdram_pkg::OFS_EXT: prdata_nxt[sdram_pkg::ADDR_W-1:0] = ext_r;
      sdram_pkg::OFS_BURST: prdata_nxt[COL_W:0] = {read_r, start_r};
      default: hit = 1'b0;
    endcase
    pready_nxt = psel & ~penable;
    pslverr_nxt = psel & ~penable & ~hit;
    if (!(psel && !penable && !pwrite)) begin
      prdata_nxt = '0;
    end
    ready_nxt = (init_nxt == sdram_pkg::INIT_READY);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strict_r <= sdram_pkg::CTRL_STRICT_RST;
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      strict_r <= strict_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      ready_r <= ready_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign init_ready = ready_r;

endmodule

//--- sim/sdram_init_mode_burst_props.sv
/* assertions on the apb and beat ports of the sdram front end.
   assumes: bound into sdram_init_mode_burst, one pclk domain. */
`timescale 1ns/1ps
module sdram_init_mode_burst_props #(
  parameter int COL_W = 10
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic [sdram_pkg::PADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // link and beats
  input wire logic mem_ck,
  input wire sdram_pkg::pins_s mem_pins,
  input wire logic [COL_W-1:0] beat_col,
  input wire logic beat_valid,
  input wire logic beat_read,
  input wire logic init_ready
);
  logic [6:0] gap_r;
  logic [COL_W-1:0] prev_r;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles since the last beat, so a burst can be told from the next one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r <= 7'h64;
      prev_r <= '0;
    end else if (beat_valid) begin
      gap_r <= 7'h00;
      prev_r <= beat_col;
    end else if (gap_r < 7'h64) begin
      gap_r <= gap_r + 7'h01;
    end
  end
  // ****************************************
  // apb and beat relations
  // ****************************************
  AST_READY_NEXT: assert property (psel && !penable |=> pready) else $error("pready late");
  AST_READY_ACCESS: assert property (pready |-> psel && penable) else $error("stray pready");
  AST_SLVERR_READY: assert property (pslverr |-> pready) else $error("stray pslverr");
  AST_UNMAPPED: assert property (psel && !penable && paddr > sdram_pkg::OFS_BURST
    |=> pready && pslverr && prdata == 32'h0000_0000) else $error("unmapped not refused");
  AST_PRDATA_ZERO: assert property (!pready |-> prdata == 32'h0000_0000) else $error("prdata");
  AST_MODE_WIDTH: assert property (pready && !pwrite && paddr == sdram_pkg::OFS_MODE
    |-> prdata[31:13] == '0) else $error("mode too wide");
  AST_BEAT_GATED: assert property (beat_valid |-> init_ready) else $error("early beat");
  AST_BEAT_GAP: assert property (beat_valid |=> !beat_valid [*5]) else $error("beat gap");
  AST_BEAT_BLOCK: assert property (beat_valid && gap_r < 7'h0C
    |-> beat_col[COL_W-1:4] == prev_r[COL_W-1:4]) else $error("left block");
  COV_READ_BEAT: cover property (beat_valid && beat_read);
  COV_READY: cover property ($rose(init_ready));
  COV_SLVERR: cover property (pslverr);
endmodule
bind sdram_init_mode_burst sdram_init_mode_burst_props #(.COL_W(COL_W)) props (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mem_ck(mem_ck), .mem_pins(mem_pins), .beat_col(beat_col), .beat_valid(beat_valid),
  .beat_read(beat_read), .init_ready(init_ready));

//--- sim/sdram_ctl_model.sv
/* behavioural memory controller driving the command link.
   assumes: link clock runs free; pins move on its falling edge. */
`timescale 1ns/1ps
module sdram_ctl_model #(
  parameter int STABLE_RISES = 2500,
  parameter int GAP_RISES = 2
) (
  // link toward the device
  output logic mem_ck,
  output sdram_pkg::pins_s mem_pins
);
  int rises = 0;
  // 80 ns clock, phase unrelated to pclk; cke high before it starts
  initial begin
    mem_ck = 1'b0;
    mem_pins = {1'b1, 1'b1, 3'h7, 2'h0, 13'h0000};
    #7.3;
    forever #40 mem_ck = ~mem_ck;
  end
  // rise counter, read by the bench for latency
  always @(posedge mem_ck) rises <= rises + 1;
  // one command around a rise, then nop with the released lines inverted
  task automatic issue(input logic [2:0] c, input logic [1:0] ba, input logic [12:0] a,
    input logic cke);
    @(negedge mem_ck);
    mem_pins <= {cke, 1'b0, c, ba, a};
    @(negedge mem_ck);
    mem_pins <= {1'b1, 1'b0, sdram_pkg::CMD_NOP, ~ba, ~a};
  endtask
  task automatic gap(input int n);
    repeat (n) @(posedge mem_ck);
  endtask
  // full power-up sequence; ext loaded first since order is free
  task automatic init(input logic [12:0] mode, input logic [12:0] ext);
    gap(STABLE_RISES);
    issue(sdram_pkg::CMD_PRE, 2'h0, 13'h0400, 1'b1);
    gap(GAP_RISES);
    repeat (2) begin
      issue(sdram_pkg::CMD_AREF, 2'h0, 13'h0000, 1'b1);
      gap(GAP_RISES);
    end
    issue(sdram_pkg::CMD_LMR, sdram_pkg::BA_EXT, ext, 1'b1);
    gap(GAP_RISES);
    issue(sdram_pkg::CMD_LMR, sdram_pkg::BA_MODE, mode, 1'b1);
    gap(GAP_RISES);
  endtask
endmodule

//--- sim/test_sdram_init_mode_burst.sv
/* self-checking bench: apb master, controller model, beat collector.
   assumes: design, package, model and checker compiled before it. */
`timescale 1ns/1ps
module test_sdram_init_mode_burst;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic mem_ck, beat_valid, beat_read, init_ready, e;
  logic [sdram_pkg::PADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [9:0] beat_col;
  logic [10:0] got[$];
  sdram_pkg::pins_s mem_pins;
  int errors = 0, checks_done = 0, seed = 72, cyc = 0, cmd_rise = 0, lat = 0;
  sdram_init_mode_burst dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_ck(mem_ck), .mem_pins(mem_pins), .beat_col(beat_col),
    .beat_valid(beat_valid), .beat_read(beat_read), .init_ready(init_ready));
  sdram_ctl_model #(.STABLE_RISES(2500)) ctl (.mem_ck(mem_ck), .mem_pins(mem_pins));
  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // hang guard: two full power-ups dominate the run
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 99000) begin
      errors++;
      end_sim();
    end
  end
  // beats sampled mid-cycle, where the pulse has settled
  always @(negedge pclk) begin
    if (beat_valid === 1'b1) begin
      if (got.size() == 0) lat = ctl.rises - cmd_rise;
      got.push_back({beat_read, beat_col});
    end
  end
  // ****************************************
  // tasks and expectations
  // ****************************************
  task automatic end_sim();
    if (errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] x, input logic [31:0] y);
    checks_done++;
    if (y !== x) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, x, y);
    end
  endtask
  // held until pready is seen high; released at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready and read data are taken at the rising edge that ends the access
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] m,
    input logic [31:0] x);
    // reads ignore pwdata, so random data there must not disturb anything
    apb(1'b0, a, $random(seed));
    chk(what, x, r & m);
  endtask
  function automatic logic [9:0] exp_col(input logic [2:0] blc, input logic bt,
    input logic [9:0] s, input logic [9:0] i);
    logic [9:0] m;
    m = (10'h001 << blc) - 10'h001;
    return (s & ~m) | ((bt ? (s ^ i) : (s + i)) & m);
  endfunction
  // load mode, run one burst, compare columns, count and latency
  task automatic burst(input logic [2:0] blc, input logic bt, input logic [2:0] cl,
    input logic [9:0] s, input logic rd);
    logic [12:0] mode;
    mode = {6'h00, cl, bt, blc};
    got.delete();
    ctl.issue(sdram_pkg::CMD_LMR, sdram_pkg::BA_MODE, mode, 1'b1);
    ctl.gap(2);
    chk("beats on reload", 32'h0000_0000, got.size());
    rchk("mode", sdram_pkg::OFS_MODE, 32'h0000_1FFF, {19'h0_0000, mode});
    ctl.issue(rd ? sdram_pkg::CMD_READ : sdram_pkg::CMD_WRITE, 2'h0, {3'h0, s}, 1'b1);
    cmd_rise = ctl.rises;
    ctl.gap(12);
    chk("beat count", 32'h0000_0001 << blc, got.size());
    chk("latency", rd ? cl - 3'h1 : 3'h1, lat);
    foreach (got[i]) chk("beat", {rd, exp_col(blc, bt, s, i[9:0])}, got[i]);
    rchk("burst", sdram_pkg::OFS_BURST, 32'h0000_07FF, {21'h00_0000, rd, s});
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rchk("mode reset", sdram_pkg::OFS_MODE, 32'h0000_1FFF, 32'h0000_0031);
    ctl.issue(sdram_pkg::CMD_READ, 2'h0, 13'h0005, 1'b1);
    ctl.gap(6);
    chk("beats before init", 32'h0000_0000, got.size());
    rchk("status", sdram_pkg::OFS_STATUS, 32'h0000_0003, 32'h0000_0002);
    apb(1'b1, sdram_pkg::OFS_CTRL, 32'h0000_0003);
    rchk("status clear", sdram_pkg::OFS_STATUS, 32'h0000_0002, 32'h0000_0000);
    // with strict off a bad command is dropped without raising the flag
    apb(1'b1, sdram_pkg::OFS_CTRL, 32'h0000_0000);
    rchk("strict off", sdram_pkg::OFS_CTRL, 32'h0000_0003, 32'h0000_0000);
    ctl.issue(sdram_pkg::CMD_AREF, 2'h0, 13'h0000, 1'b1);
    ctl.gap(2);
    rchk("err masked", sdram_pkg::OFS_STATUS, 32'h0000_0002, 32'h0000_0000);
    apb(1'b1, sdram_pkg::OFS_CTRL, 32'h0000_0002);
    rchk("strict on", sdram_pkg::OFS_CTRL, 32'h0000_0003, 32'h0000_0002);
    ctl.init(13'h0032, 13'h0005);
    rchk("ready", sdram_pkg::OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
    rchk("ext", sdram_pkg::OFS_EXT, 32'h0000_1FFF, 32'h0000_0005);
    rchk("mode init", sdram_pkg::OFS_MODE, 32'h0000_1FFF, 32'h0000_0032);
    // software cannot write the mode copy; only the link loads it
    apb(1'b1, sdram_pkg::OFS_MODE, $random(seed));
    chk("ro write error", 32'h0000_0000, {31'h0, e});
    rchk("mode ro", sdram_pkg::OFS_MODE, 32'h0000_1FFF, 32'h0000_0032);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, {31'h0, e});
    ctl.issue(sdram_pkg::CMD_LMR, sdram_pkg::BA_MODE, 13'h0082, 1'b1);
    ctl.gap(2);
    rchk("reserved", sdram_pkg::OFS_STATUS, 32'h0000_0004, 32'h0000_0004);
    // bank code 01 selects neither mode register
    ctl.issue(sdram_pkg::CMD_LMR, 2'h1, 13'h1FFF, 1'b1);
    ctl.gap(2);
    rchk("mode ba01", sdram_pkg::OFS_MODE, 32'h0000_1FFF, 32'h0000_0082);
    rchk("ext ba01", sdram_pkg::OFS_EXT, 32'h0000_1FFF, 32'h0000_0005);
    burst(sdram_pkg::BL_CODE_4, 1'b0, 3'h3, 10'h001, 1'b1);
    burst(sdram_pkg::BL_CODE_4, 1'b1, 3'h3, 10'h001, 1'b1);
    burst(sdram_pkg::BL_CODE_16, 1'b1, 3'h2, 10'h3F5, 1'b0);
    for (int i = 0; i < 16; i++) begin
      burst(sdram_pkg::BL_CODE_2 + 3'(i[1:0]), i[2], i[3] ? 3'h3 : 3'h2,
        10'($random(seed)), 1'($random(seed)));
    end
    rchk("mode kept", sdram_pkg::OFS_MODE, 32'h0000_1FFF, 32'h0000_003C);
    ctl.issue(sdram_pkg::CMD_BST, 2'h0, 13'h0000, 1'b0);
    ctl.gap(2);
    rchk("mode dpd", sdram_pkg::OFS_MODE, 32'h0000_1FFF, 32'h0000_0031);
    rchk("ready dpd", sdram_pkg::OFS_STATUS, 32'h0000_0005, 32'h0000_0004);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk("mode lost", sdram_pkg::OFS_MODE, 32'h0000_1FFF, 32'h0000_0031);
    // the sticky reserved flag survives deep power-down but not power loss
    rchk("status lost", sdram_pkg::OFS_STATUS, 32'h0000_0005, 32'h0000_0000);
    ctl.init(13'h0023, 13'h0000);
    burst(sdram_pkg::BL_CODE_8, 1'b0, 3'h2, 10'h00E, 1'b1);
    end_sim();
  end
endmodule
